// file: hw/eps_sequencer.sv
// exception priority sequencer: ranking, five-step entry, reset and fault halt
// Notes on behaviour
// - group 0 first, interrupt 4.3 last
// - address error beats bus error, both suspend
// - reset abandons work, pushes nothing
// - group 2 taken during its instruction
// - group 3 taken before instruction runs
// - group 4 waits; trace, breakpoint, interrupt
// - reset preempts running sequence, group 1 fault only a group 2-4 one
// - next pending sequence starts straight after
// - reset discards all other pending exceptions
// - frame: status, pc, offset, format 0000
// - copy status, set S, clear traces
// - interrupt vector via acknowledge read, space 7
// - non-reset exceptions push supervisor stack frame
// - vector address is base plus four times number
// - reset from pin or internal line
// - reset: traces off, S set, mask 7, base 0
// - reset reads stack pointer then pc
// - reset saves no old pc or status
// - fault during reset sequence halts, halt shown
// - reset instruction only drives reset line
// - bus fault line raises bus error
// - halted until reset input asserted
// - bus error continues at vector 2
`timescale 1ns/100ps
`default_nettype none
module eps_sequencer
   import eps_pkg::*;
(
   // clock, reset, freeze
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic EN,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   // core context and requests
   input wire logic [15:0] CORE_SR,
   input wire logic [31:0] CORE_PC,
   input wire logic [31:0] CORE_SSP,
   input wire logic INSN_BOUNDARY,
   input wire logic INT_RESET,
   input wire logic SW_RESET_REQ,
   input wire logic ADDR_ERR_REQ,
   input wire logic GRP2_REQ,
   input wire logic [7:0] GRP2_VEC,
   input wire logic GRP3_REQ,
   input wire logic [7:0] GRP3_VEC,
   input wire logic TRACE_REQ,
   input wire logic HWBP_REQ,
   input wire logic IRQ_REQ,
   input wire logic [2:0] IRQ_LEVEL,
   // bus fault pin
   input wire logic BUS_FAULT_LINE_N,
   // system bus master
   output eps_mem_type MEM_O,
   input wire logic MEM_ACK,
   input wire logic MEM_ERR,
   input wire logic [31:0] MEM_RDATA,
   // results to the core
   output logic EXC_BUSY,
   output logic EXC_DONE,
   output logic [15:0] NEW_SR,
   output logic [31:0] NEW_PC,
   output logic [31:0] NEW_SSP,
   output logic [7:0] VEC_NUM,
   output logic HALT_N,
   output logic RESET_LINE_OUT
);
   eps_regs_type s_q;
   eps_regs_type s_d;
   logic bnd;
   logic any_sel;
   eps_exc_type sel;
   logic [7:1] avail;
   logic acked;
   logic bus_err;
   logic grp1;
   logic [7:0] ivec;
   logic [7:0] v;

   // group 4 only at a boundary or right after a finished sequence
   assign bnd = INSN_BOUNDARY | s_q.after;
   assign avail = s_q.pend & {bnd, bnd, bnd, 4'hF};

   always_comb begin
      sel = X_IRQ;
      any_sel = 1'b0;
      for (int i = 7; i >= 1; i--) begin
         if (avail[i]) begin
            sel = eps_exc_type'(3'(i));
            any_sel = 1'b1;
         end
      end
   end

   always_comb begin
      case (s_q.cur)
         X_ADDR: ivec = VEC_ADDR;
         X_BUS: ivec = VEC_BUS;
         X_G2: ivec = s_q.g2_vec;
         X_G3: ivec = s_q.g3_vec;
         X_TRACE: ivec = VEC_TRACE;
         X_HWBP: ivec = VEC_HWBP;
         default: ivec = VEC_RESET;
      endcase
   end

   assign acked = s_q.mem.req & MEM_ACK;
   assign bus_err = (acked & MEM_ERR) | ~s_q.bf2;
   assign grp1 = bus_err | ADDR_ERR_REQ;

   always_comb begin
      s_d = s_q;
      v = ivec;
      s_d.bf1 = BUS_FAULT_LINE_N;
      s_d.bf2 = s_q.bf1;
      s_d.done = 1'b0;
      // register read data captured in setup so it comes from a flop
      if (PSEL && !PENABLE) begin
         case (PADDR)
            OFS_VEC_BASE: begin
               s_d.prdata = s_q.vec_base;
               s_d.slverr = 1'b0;
            end
            OFS_STATUS: begin
               s_d.prdata = {6'h00, s_q.vec, s_q.pend, 3'b000, s_q.cur,
                  s_q.st, ~HALT_N, s_q.after};
               s_d.slverr = 1'b0;
            end
            default: begin
               s_d.prdata = 32'h00000000;
               s_d.slverr = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && PWRITE && PADDR == OFS_VEC_BASE) begin
         s_d.vec_base = PWDATA;
      end
      case (s_q.st)
         S_IDLE: begin
            if (any_sel) begin
               s_d.cur = sel;
               s_d.st = S_STATUS;
            end else begin
               s_d.after = 1'b0;
            end
         end
         S_STATUS: begin
            s_d.after = 1'b0;
            s_d.sr_copy = CORE_SR;
            s_d.ret_pc = CORE_PC;
            s_d.sp = CORE_SSP;
            s_d.sr_new = CORE_SR;
            s_d.sr_new[SR_S] = 1'b1;
            s_d.sr_new[SR_TRACE_HI] = 1'b0;
            s_d.sr_new[SR_TRACE_LO] = 1'b0;
            if (s_q.cur == X_RESET) begin
               s_d.sr_new[SR_IPM +: 3] = IPM_RESET;
               s_d.vec_base = VEC_BASE_RESET;
               s_d.vec = VEC_RESET;
               // no frame at all on reset, straight to the vector
               s_d.mem = '{1'b1, 1'b0, FC_SUP_PROG, RST_VEC_SP, 32'h0};
               s_d.st = S_FETCH_SP;
            end else begin
               if (s_q.cur == X_IRQ) begin
                  s_d.sr_new[SR_IPM +: 3] = s_q.irq_lvl;
                  s_d.mem = '{1'b1, 1'b0, FC_CPU,
                     IACK_BASE | {28'h0, s_q.irq_lvl, 1'b0}, 32'h0};
               end
               s_d.st = S_VECTOR;
            end
         end
         S_VECTOR: begin
            if (s_q.cur != X_IRQ || (acked && !MEM_ERR)) begin
               if (s_q.cur == X_IRQ) begin
                  v = MEM_RDATA[7:0];
               end
               s_d.vec = v;
               s_d.mem = '{1'b1, 1'b1, FC_SUP_DATA, s_q.sp - FRAME_LO,
                  {s_q.ret_pc[15:0], FMT_SHORT, 2'b00, v, 2'b00}};
               s_d.st = S_PUSH_LO;
            end
         end
         S_PUSH_LO: begin
            if (acked) begin
               s_d.mem = '{1'b1, 1'b1, FC_SUP_DATA, s_q.sp - FRAME_HI,
                  {s_q.sr_copy, s_q.ret_pc[31:16]}};
               s_d.st = S_PUSH_HI;
            end
         end
         S_PUSH_HI: begin
            if (acked) begin
               s_d.sp = s_q.sp - FRAME_HI;
               s_d.mem = '{1'b1, 1'b0, FC_SUP_DATA,
                  s_q.vec_base + {22'h0, s_q.vec, 2'b00}, 32'h0};
               s_d.st = S_FETCH_PC;
            end
         end
         S_FETCH_SP: begin
            if (acked) begin
               s_d.sp = MEM_RDATA;
               s_d.mem = '{1'b1, 1'b0, FC_SUP_PROG, RST_VEC_PC, 32'h0};
               s_d.st = S_FETCH_PC;
            end
         end
         S_FETCH_PC: begin
            if (acked) begin
               s_d.mem.req = 1'b0;
               s_d.pc_new = MEM_RDATA;
               if (s_q.cur != X_RESET) begin
                  s_d.pend[s_q.cur] = 1'b0;
               end
               s_d.done = 1'b1;
               s_d.after = 1'b1;
               s_d.st = S_IDLE;
            end
         end
         S_HALT: begin
            s_d.mem.req = 1'b0;
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase
      // a fault mid-sequence: double fault halts, else it preempts
      if (s_q.st != S_IDLE && s_q.st != S_HALT && grp1) begin
         s_d.mem.req = 1'b0;
         s_d.done = 1'b0;
         if (s_q.cur == X_RESET || s_q.cur == X_ADDR || s_q.cur == X_BUS) begin
            s_d.st = S_HALT;
         end else begin
            s_d.st = S_IDLE;
            if (s_q.st == S_FETCH_PC && acked && !MEM_ERR) begin
               s_d.pend[s_q.cur] = 1'b0;
            end
         end
      end
      // sets after clears so an arriving request is kept unless the internal reset line below discards it
      if (ADDR_ERR_REQ) begin
         s_d.pend[X_ADDR] = 1'b1;
      end
      if (bus_err) begin
         s_d.pend[X_BUS] = 1'b1;
      end
      if (GRP2_REQ) begin
         s_d.pend[X_G2] = 1'b1;
         s_d.g2_vec = GRP2_VEC;
      end
      if (GRP3_REQ) begin
         s_d.pend[X_G3] = 1'b1;
         s_d.g3_vec = GRP3_VEC;
      end
      if (TRACE_REQ) begin
         s_d.pend[X_TRACE] = 1'b1;
      end
      if (HWBP_REQ) begin
         s_d.pend[X_HWBP] = 1'b1;
      end
      if (IRQ_REQ) begin
         s_d.pend[X_IRQ] = 1'b1;
         s_d.irq_lvl = IRQ_LEVEL;
      end
      // internal reset line: abandon everything, even a bus access in flight
      if (INT_RESET && s_q.st != S_HALT) begin
         s_d.pend = '0;
         s_d.cur = X_RESET;
         s_d.st = S_STATUS;
         s_d.mem.req = 1'b0;
         s_d.after = 1'b0;
         s_d.done = 1'b0;
      end
      // reset instruction touches nothing but the outgoing reset line
      if (SW_RESET_REQ) begin
         s_d.rst_cnt = RST_DRIVE_CNT;
      end else if (s_q.rst_cnt != 10'h000) begin
         s_d.rst_cnt = s_q.rst_cnt - 10'h001;
      end
      s_d.rst_drv = (s_d.rst_cnt != 10'h000);
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_q <= REGS_RESET;
      end else if (EN) begin
         s_q <= s_d;
      end
   end

   assign PREADY = EN;
   assign PRDATA = s_q.prdata;
   assign PSLVERR = s_q.slverr;
   assign MEM_O = s_q.mem;
   assign EXC_BUSY = (s_q.st != S_IDLE) | any_sel;
   assign EXC_DONE = s_q.done;
   assign NEW_SR = s_q.sr_new;
   assign NEW_PC = s_q.pc_new;
   assign NEW_SSP = s_q.sp;
   assign VEC_NUM = s_q.vec;
   assign HALT_N = (s_q.st != S_HALT);
   assign RESET_LINE_OUT = s_q.rst_drv;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   AST_RESET_DISCARDS: assert property (
      (EN && INT_RESET && s_q.st != S_HALT) |=> (s_q.pend == 7'h00 && s_q.cur == X_RESET
         && s_q.st == S_STATUS)) else $error("reset did not discard pending work");
   AST_RESET_INIT: assert property (
      (EN && s_q.st == S_STATUS && s_q.cur == X_RESET && !INT_RESET && !grp1)
      |=> (s_q.vec_base == VEC_BASE_RESET && s_q.sr_new[SR_S]
         && s_q.sr_new[SR_IPM +: 3] == IPM_RESET
         && s_q.sr_new[SR_TRACE_HI:SR_TRACE_LO] == 2'b00))
      else $error("reset state not initialised");
   AST_ADDR_OVER_BUS: assert property (
      (EN && s_q.st == S_IDLE && s_q.pend[X_ADDR] && s_q.pend[X_BUS] && !INT_RESET)
      |=> s_q.cur == X_ADDR) else $error("bus error taken before address error");
   AST_TRACE_FIRST: assert property (
      (EN && s_q.st == S_IDLE && s_q.pend[X_TRACE] && s_q.pend[X_IRQ] && bnd
         && s_q.pend[4:1] == 4'h0 && !INT_RESET) |=> s_q.cur == X_TRACE)
      else $error("group 4 order broken");
   AST_RESET_NO_PUSH: assert property (
      (s_q.cur == X_RESET && s_q.st != S_IDLE) |-> !(s_q.mem.req && s_q.mem.wr))
      else $error("reset wrote to memory");
   AST_IACK_SPACE: assert property (
      (s_q.st == S_VECTOR && s_q.cur == X_IRQ && s_q.mem.req)
      |-> (s_q.mem.fc == FC_CPU && !s_q.mem.wr)) else $error("bad acknowledge cycle");
   AST_FRAME_FORMAT: assert property (
      (s_q.st == S_PUSH_LO && s_q.mem.req) |-> (s_q.mem.wdata[15:12] == FMT_SHORT
         && s_q.mem.wdata[11:0] == {s_q.vec, 2'b00} && s_q.mem.wdata[31:16] == s_q.ret_pc[15:0]))
      else $error("frame word wrong");
   AST_VECTOR_ADDR: assert property (
      (s_q.st == S_FETCH_PC && s_q.mem.req && s_q.cur != X_RESET)
      |-> s_q.mem.addr == s_q.vec_base + {22'h0, s_q.vec, 2'b00})
      else $error("vector address wrong");
   AST_STATUS_STEP: assert property (
      (EN && s_q.st == S_STATUS && !INT_RESET) |=> (s_q.sr_new[SR_S]
         && s_q.sr_new[SR_TRACE_HI:SR_TRACE_LO] == 2'b00 && s_q.sr_copy == $past(CORE_SR)))
      else $error("status step wrong");
   AST_DOUBLE_FAULT: assert property (
      (EN && s_q.cur == X_RESET && (s_q.st == S_FETCH_SP || s_q.st == S_FETCH_PC)
         && acked && MEM_ERR && !INT_RESET)
      |=> (s_q.st == S_HALT && !HALT_N)) else $error("no halt on double fault");
   AST_HALT_HOLDS: assert property (
      (s_q.st == S_HALT) |=> (!HALT_N && !MEM_O.req) [*4]) else $error("halt left");
   AST_SW_RESET: assert property (
      (EN && SW_RESET_REQ) |=> (RESET_LINE_OUT && $stable(s_q.vec_base) && $stable(s_q.st)))
      else $error("reset instruction misbehaved");

   COV_RESET_DONE: cover property (s_q.cur == X_RESET && EXC_DONE);
   COV_IRQ_DONE: cover property (s_q.cur == X_IRQ && EXC_DONE);
   COV_PREEMPT: cover property (s_q.cur == X_TRACE && s_q.st == S_PUSH_LO ##1 s_q.cur == X_BUS);
   COV_HALT: cover property (!HALT_N);
endmodule
`default_nettype wire

// file: hw/eps_pkg.sv
// constants, types and reset state for the exception sequencer
package eps_pkg;
   localparam int CLK_NS = 20;
   localparam int RST_DRIVE_NS = 10240;
   localparam int RST_DRIVE_CYC = RST_DRIVE_NS / CLK_NS;
   localparam logic [9:0] RST_DRIVE_CNT = 10'(RST_DRIVE_CYC);
   localparam logic [11:0] OFS_VEC_BASE = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [31:0] VEC_BASE_RESET = 32'h00000000;
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_BUS = 8'h02;
   localparam logic [7:0] VEC_ADDR = 8'h03;
   localparam logic [7:0] VEC_TRACE = 8'h09;
   localparam logic [7:0] VEC_HWBP = 8'h0C;
   localparam logic [2:0] FC_SUP_DATA = 3'h5;
   localparam logic [2:0] FC_SUP_PROG = 3'h6;
   localparam logic [2:0] FC_CPU = 3'h7;
   localparam logic [31:0] IACK_BASE = 32'hFFFFFFF0;
   localparam logic [31:0] RST_VEC_SP = 32'h00000000;
   localparam logic [31:0] RST_VEC_PC = 32'h00000004;
   localparam logic [31:0] FRAME_LO = 32'h00000004;
   localparam logic [31:0] FRAME_HI = 32'h00000008;
   localparam logic [3:0] FMT_SHORT = 4'h0;
   localparam int SR_TRACE_HI = 15;
   localparam int SR_TRACE_LO = 14;
   localparam int SR_S = 13;
   localparam int SR_IPM = 8;
   localparam logic [2:0] IPM_RESET = 3'h7;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_STATUS = 3'b001, S_VECTOR = 3'b010, S_PUSH_LO = 3'b011,
      S_PUSH_HI = 3'b100, S_FETCH_SP = 3'b101, S_FETCH_PC = 3'b110, S_HALT = 3'b111
   } eps_state_type;

   typedef enum logic [2:0] {
      X_RESET = 3'b000, X_ADDR = 3'b001, X_BUS = 3'b010, X_G2 = 3'b011,
      X_G3 = 3'b100, X_TRACE = 3'b101, X_HWBP = 3'b110, X_IRQ = 3'b111
   } eps_exc_type;

   typedef struct packed {
      logic req;
      logic wr;
      logic [2:0] fc;
      logic [31:0] addr;
      logic [31:0] wdata;
   } eps_mem_type;

   typedef struct packed {
      eps_state_type st;
      eps_exc_type cur;
      logic [7:1] pend;
      logic [7:0] g2_vec;
      logic [7:0] g3_vec;
      logic [2:0] irq_lvl;
      logic [31:0] vec_base;
      logic [15:0] sr_copy;
      logic [15:0] sr_new;
      logic [31:0] ret_pc;
      logic [31:0] sp;
      logic [31:0] pc_new;
      logic [7:0] vec;
      eps_mem_type mem;
      logic done;
      logic after;
      logic [9:0] rst_cnt;
      logic rst_drv;
      logic bf1;
      logic bf2;
      logic [31:0] prdata;
      logic slverr;
   } eps_regs_type;

   localparam eps_regs_type REGS_RESET = '{st: S_STATUS, cur: X_RESET, vec_base: VEC_BASE_RESET,
      bf1: 1'b1, bf2: 1'b1, default: '0};
endpackage

// file: bench/eps_mem_model.sv
// system bus responder standing in for memory and interrupt acknowledge
`timescale 1ns/100ps
`default_nettype none
module eps_mem_model
   import eps_pkg::*;
#(
   parameter logic [31:0] RST_SP = 32'h00001000,
   parameter logic [31:0] RST_PC = 32'h00000400
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bus from the sequencer
   input wire eps_mem_type mem_o,
   output logic mem_ack,
   output logic mem_err,
   output logic [31:0] mem_rdata,
   // test controls
   input wire logic [1:0] dly,
   input wire logic err_arm,
   input wire logic [31:0] err_addr,
   input wire logic [7:0] irq_vec
);
   logic [2:0] cnt;
   logic [31:0] rd;
   logic [31:0] rd_q;
   logic used;
   always_comb begin
      if (mem_o.fc == FC_CPU) begin
         rd = {24'h000000, irq_vec};
      end else if (mem_o.fc == FC_SUP_PROG) begin
         rd = (mem_o.addr == 32'h00000000) ? RST_SP : RST_PC;
      end else begin
         rd = mem_o.addr ^ 32'h12340000;
      end
   end
   // data line never shows a stale value outside the ack cycle
   assign mem_rdata = mem_ack ? rd_q : ~rd_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 3'h0;
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         rd_q <= 32'h00000000;
         used <= 1'b0;
      end else begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         if (!err_arm) begin
            used <= 1'b0;
         end
         if (mem_o.req && !mem_ack) begin
            cnt <= cnt + 3'h1;
            if (cnt >= {1'b0, dly}) begin
               cnt <= 3'h0;
               mem_ack <= 1'b1;
               rd_q <= rd;
               if (err_arm && !used && mem_o.addr == err_addr) begin
                  mem_err <= 1'b1;
                  used <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: bench/exception_priority_sequencer_tb.sv
// self-checking bench for the exception sequencer
`timescale 1ns/100ps
`default_nettype none
module exception_priority_sequencer_tb;
   import eps_pkg::*;
   localparam logic [15:0] CSR = 16'hC300;
   localparam logic [31:0] CSSP = 32'h00008000;
   localparam logic [31:0] RSP = 32'h00001000;
   localparam logic [31:0] RPC = 32'h00000400;
   localparam logic [7:0] F_AE = 8'h01, F_G2 = 8'h02, F_G3 = 8'h04, F_TR = 8'h08;
   localparam logic [7:0] F_HB = 8'h10, F_IQ = 8'h20, F_SW = 8'h40, F_IR = 8'h80;
   logic clk, resetn, psel, penable, pwrite, bound, bfl_n, ack, merr, pready, pslverr;
   logic busy, done, halt_n, rst_out, err_arm, sv;
   logic [7:0] rq, g2v, g3v, ivec, vnum;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cpc, vtb, eaddr, new_pc, new_ssp, rdata, rv;
   logic [31:0] seed = 32'h000018BD;
   logic [15:0] new_sr;
   logic [2:0] ilvl;
   logic [1:0] dly;
   eps_mem_type mem;
   int fail_count, samples_checked, n;
   int qv[$], qs[$];
   logic [31:0] wq[$];

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic ex(int v, int s);
      qv.push_back(v);
      qs.push_back(s);
   endtask
   task automatic fire(logic [7:0] m);
      rq <= m;
      @(posedge clk);
      rq <= 8'h00;
      // one idle edge so back-to-back calls never reassign rq in one step
      @(posedge clk);
   endtask
   task automatic settle();
      n = 0;
      while ((qv.size() != 0 || busy !== 1'b0) && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("pending results", 32'h0, 32'(qv.size()));
      repeat (4) @(posedge clk);
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      rv = prdata;
      sv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // behavioural model: expected vector, status and frame at each finished sequence
   task automatic on_done();
      int v;
      int s;
      if (qv.size() == 0) begin
         chk("unexpected done", 32'h0, 32'h1);
         return;
      end
      v = qv.pop_front();
      s = qs.pop_front();
      chk("vector", 32'(v), 32'(vnum));
      chk("status", 32'(s), 32'(new_sr[15:8]));
      if (v == 0) begin
         chk("reset pc", RPC, new_pc);
         chk("reset sp", RSP, new_ssp);
         chk("reset frame", 32'h0, 32'(wq.size()));
         wq.delete();
      end else begin
         chk("pc", (vtb + 32'(v) * 4) ^ 32'h12340000, new_pc);
         chk("ssp", CSSP - 8, new_ssp);
         chk("lo addr", CSSP - 4, wq.pop_front());
         chk("lo data", {cpc[15:0], FMT_SHORT, 2'b00, 8'(v), 2'b00}, wq.pop_front());
         chk("hi addr", CSSP - 8, wq.pop_front());
         chk("hi data", {CSR, cpc[31:16]}, wq.pop_front());
      end
   endtask
   always @(posedge clk) begin
      dly <= 2'(xs());
      if (mem.req && ack && !merr && mem.wr) begin
         wq.push_back(mem.addr);
         wq.push_back(mem.wdata);
      end
      if (mem.req && ack && mem.fc == FC_CPU) begin
         chk("iack addr", IACK_BASE | (32'(ilvl) << 1), mem.addr);
      end
      if (done) begin
         on_done();
      end
   end

   eps_sequencer uut (
      .CLK(clk), .RESETN(resetn), .EN(1'b1),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
      .CORE_SR(CSR), .CORE_PC(cpc), .CORE_SSP(CSSP), .INSN_BOUNDARY(bound),
      .INT_RESET(rq[7]), .SW_RESET_REQ(rq[6]), .ADDR_ERR_REQ(rq[0]),
      .GRP2_REQ(rq[1]), .GRP2_VEC(g2v), .GRP3_REQ(rq[2]), .GRP3_VEC(g3v),
      .TRACE_REQ(rq[3]), .HWBP_REQ(rq[4]), .IRQ_REQ(rq[5]), .IRQ_LEVEL(ilvl),
      .BUS_FAULT_LINE_N(bfl_n), .MEM_O(mem), .MEM_ACK(ack), .MEM_ERR(merr),
      .MEM_RDATA(rdata), .EXC_BUSY(busy), .EXC_DONE(done), .NEW_SR(new_sr),
      .NEW_PC(new_pc), .NEW_SSP(new_ssp), .VEC_NUM(vnum), .HALT_N(halt_n),
      .RESET_LINE_OUT(rst_out)
   );
   eps_mem_model #(.RST_SP(RSP), .RST_PC(RPC)) mem_partner (
      .clk(clk), .resetn(resetn), .mem_o(mem), .mem_ack(ack), .mem_err(merr),
      .mem_rdata(rdata), .dly(dly), .err_arm(err_arm), .err_addr(eaddr), .irq_vec(ivec)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #(20 * 30000);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {resetn, psel, penable, pwrite, err_arm, rq} = '0;
      {bound, bfl_n} = 2'b11;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      eaddr = CSSP - 4;
      cpc = xs();
      g2v = 8'h20 | 8'(xs() & 32'hF);
      g3v = 8'h04;
      ivec = 8'h40 | 8'(xs() & 32'h3F);
      ilvl = 3'(xs() % 7) + 3'h1;
      vtb = 32'h00000000;
      ex(0, 8'h27);
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      settle();
      apb(1'b0, OFS_VEC_BASE, 32'h0);
      chk("base reset", VEC_BASE_RESET, rv);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 32'h1, 32'(sv));
      chk("unmapped data", 32'h0, rv);
      vtb = xs() & 32'h00FFFFFC;
      apb(1'b1, OFS_VEC_BASE, vtb);
      apb(1'b0, OFS_VEC_BASE, 32'h0);
      chk("base", vtb, rv);
      // group 4 held off until the core reaches a boundary
      bound <= 1'b0;
      ex(9, 8'h23);
      fire(F_TR);
      repeat (10) @(posedge clk);
      chk("held req", 32'h0, 32'(mem.req));
      bound <= 1'b1;
      settle();
      ex(g2v, 8'h23);
      ex(9, 8'h23);
      ex(12, 8'h23);
      ex(ivec, 8'h20 | ilvl);
      fire(F_G2 | F_TR | F_HB | F_IQ);
      settle();
      ex(g3v, 8'h23);
      ex(12, 8'h23);
      fire(F_G3 | F_HB);
      settle();
      err_arm <= 1'b1;
      ex(2, 8'h23);
      ex(9, 8'h23);
      fire(F_TR);
      settle();
      err_arm <= 1'b0;
      ex(3, 8'h23);
      ex(9, 8'h23);
      fire(F_TR);
      fire(F_AE);
      settle();
      // pin fault and address error land in one cycle: address error first
      ex(3, 8'h23);
      ex(2, 8'h23);
      bfl_n <= 1'b0;
      @(posedge clk);
      bfl_n <= 1'b1;
      @(posedge clk);
      fire(F_AE);
      settle();
      vtb = 32'h00000000;
      ex(0, 8'h27);
      fire(F_TR);
      fire(F_IR);
      settle();
      apb(1'b0, OFS_VEC_BASE, 32'h0);
      chk("base after reset", 32'h0, rv);
      fire(F_SW);
      n = 0;
      while (rst_out !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (rst_out === 1'b1 && n < 2000) begin
         chk("busy", 32'h0, 32'(busy));
         @(posedge clk);
         n++;
      end
      chk("reset drive", 32'(RST_DRIVE_CYC), 32'(n));
      // fault on the second reset read leaves the device halted
      eaddr = 32'h00000004;
      err_arm <= 1'b1;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (20) @(posedge clk);
      chk("halt", 32'h0, 32'(halt_n));
      fire(F_IR);
      fire(F_TR);
      repeat (20) @(posedge clk);
      chk("still halted", 32'h0, 32'(halt_n));
      err_arm <= 1'b0;
      ex(0, 8'h27);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      settle();
      chk("running", 32'h1, 32'(halt_n));
      tally_and_finish();
   end
endmodule
`default_nettype wire
